// >>> rtl/xmc_ctrl.sv
// Overview of operation
// - Host clears volatile bit 3; device then treats XIP as enabled, not active.
// - With XIP enabled, confirm bit 0 in the next fast read makes XIP active.
// - Active XIP: transactions start with address, no opcode, in current protocol width.
// - Confirm bit 1 leaves XIP, restores opcode decoding, sets volatile bit 3 to 1.
// - Basic-XIP variant: confirm bit 0 after any fast read makes XIP active.
// - Nonvolatile bits [11:9] selecting XIP make power-up start in XIP.
// - Confirm bit is sampled on line zero in the first dummy cycle.
// - Lines one to three are ignored for the confirm value.
// - Each sampled confirm bit of 0 keeps XIP for the next transaction.
// - Reset pin low pulse in extended/dual ends XIP, restores nonvolatile state.
// - In quad protocol the reset pin counts only while deselected.
// - Rescue bursts only end XIP; no reset, operations in progress continue.
// - Under power-on reset every operation is off and instructions are ignored.
// - During power-up init only status and flag status reads are accepted.
// - After power-up: standby, write latch and busy cleared, lock bits zero.
// - Controller flag reads 0 while an operation runs, 1 once complete.
// - Readiness polling uses single-line mode: input line zero, output line one.
// - When ready, full access uses the protocol chosen by nonvolatile configuration.
// - During access delay: hold on, reset pin off, default drive strength.
// - After an interrupted subsector erase, power-up takes up to 4.5 or 36 ms.
module xmc_ctrl #(
  parameter int unsigned ACCESS_CYC  = xmc_pkg::ACCESS_DELAY_CYC,
  parameter int unsigned REC4_CYC    = xmc_pkg::ERASE_REC_4K_CYC,
  parameter int unsigned REC32_CYC   = xmc_pkg::ERASE_REC_32K_CYC
) (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  // Serial pins
  input  wire logic        chip_sel_n_i,
  input  wire logic        serial_clk_i,
  input  wire logic [3:0]  serial_line_i,
  input  wire logic        reset_pin_n_i,
  output logic      [3:0]  serial_line_o,
  output logic      [3:0]  serial_line_oe_n_o,
  // Configuration
  input  wire logic [15:0] nvcfg_i,
  input  wire logic        basic_xip_i,
  input  wire logic        reset_pin_en_i,
  input  wire logic [1:0]  erase_recovery_i,
  input  wire logic        op_busy_i,
  // Status
  output logic             xip_active_o,
  output logic             xip_enabled_o,
  output logic [7:0]       vcfg_o,
  output logic             ready_o,
  output logic             hold_en_o,
  output logic             drive_default_o,
  output logic             reset_pin_active_o,
  output logic             write_latch_o,
  output logic [1:0]       lock_bits_o,
  output logic             cmd_valid_o,
  output logic [7:0]       cmd_code_o,
  output logic [23:0]      addr_o,
  output logic [1:0]       proto_o
);
  import xmc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_WCFG, ST_IGNORE
  } xmc_state_type;

  logic [3:0]    pins_s;
  logic          cs_n_s, sck_s, rst_n_s;
  logic          cs_s, rst_s;
  logic          sck_d1_q, cs_d1_q, rst_d1_q;
  logic          sck_rise, sck_fall, cs_fall, cs_rise, rst_fall;
  xmc_state_type state_q;
  logic [7:0]    cmd_q;
  logic [23:0]   shift_q;
  logic [5:0]    bits_q;
  logic [5:0]    burst_q;
  logic [2:0]    rescue_q;
  logic [7:0]    vcfg_q;
  logic          xip_act_q, xip_next_q, xip_pend_q;
  logic [DELAY_W+4:0] delay_q;
  logic          ready_q;
  logic [7:0]    out_byte_q;
  logic [2:0]    out_cnt_q;
  xmc_proto_type proto_q;

  xmc_sync #(.WIDTH(7)) u_sync (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .async_i ({serial_line_i, !chip_sel_n_i, serial_clk_i, !reset_pin_n_i}),
    .sync_o  ({pins_s, cs_s, sck_s, rst_s})
  );

  // Synced inverted so reset leaves select and reset pin at their idle high
  assign cs_n_s  = !cs_s;
  assign rst_n_s = !rst_s;

  function automatic xmc_proto_type nv_proto(input logic [15:0] nv);
    unique case (nv[NVCFG_PROTO_LSB+:2])
      2'b10:   nv_proto = XMC_PROTO_DUAL;
      2'b01:   nv_proto = XMC_PROTO_QUAD;
      default: nv_proto = XMC_PROTO_EXT;
    endcase
  endfunction

  function automatic logic [5:0] addr_cycles(input xmc_proto_type p);
    unique case (p)
      XMC_PROTO_QUAD: addr_cycles = 6'(ADDR_BITS / 4);
      XMC_PROTO_DUAL: addr_cycles = 6'(ADDR_BITS / 2);
      default:        addr_cycles = 6'(ADDR_BITS);
    endcase
  endfunction

  function automatic logic nv_xip(input logic [15:0] nv);
    nv_xip = nv[NVCFG_XIP_LSB+:NVCFG_XIP_W] != NVCFG_XIP_OFF;
  endfunction

  assign sck_rise = sck_s && !sck_d1_q;
  assign sck_fall = !sck_s && sck_d1_q;
  assign cs_fall  = !cs_n_s && cs_d1_q;
  assign cs_rise  = cs_n_s && !cs_d1_q;
  assign rst_fall = !rst_n_s && rst_d1_q;

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      sck_d1_q <= 1'b0;
      cs_d1_q  <= 1'b1;
      rst_d1_q <= 1'b1;
    end else begin
      sck_d1_q <= sck_s;
      cs_d1_q  <= cs_n_s;
      rst_d1_q <= rst_n_s;
    end
  end

  // Hardware reset pulse; quad only while deselected
  logic hw_reset;
  assign hw_reset = ready_q && reset_pin_en_i && rst_fall
                 && (proto_q != XMC_PROTO_QUAD || cs_n_s);

  // Access delay counter; erase recovery lengthens it
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      delay_q <= '0;
      ready_q <= 1'b0;
    end else if (!ready_q) begin
      delay_q <= delay_q + 1'b1;
      unique case (erase_recovery_i)
        2'd1:    ready_q <= delay_q >= (DELAY_W+5)'(REC4_CYC - 1);
        2'd2:    ready_q <= delay_q >= (DELAY_W+5)'(REC32_CYC - 1);
        default: ready_q <= delay_q >= (DELAY_W+5)'(ACCESS_CYC - 1);
      endcase
    end
  end

  // Protocol from nonvolatile configuration once ready
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      proto_q <= XMC_PROTO_EXT;
    end else if (!ready_q) begin
      proto_q <= XMC_PROTO_EXT;
    end else if (cs_n_s && state_q == ST_IDLE) begin
      proto_q <= nv_proto(nvcfg_i);
    end
  end

  // Rescue burst tracking
  always_ff @(posedge clock_i) begin
    if (!nrst_i || hw_reset) begin
      burst_q  <= '0;
      rescue_q <= '0;
    end else if (cs_fall) begin
      burst_q <= '0;
    end else if (!cs_n_s && sck_rise && pins_s[0] && pins_s[3]) begin
      if (burst_q != 6'h3F) burst_q <= burst_q + 6'h01;
    end else if (!cs_n_s && sck_rise) begin
      burst_q <= 6'h3F;
    end else if (cs_rise) begin
      if (burst_q == RESCUE_LEN[rescue_q]) begin
        rescue_q <= (rescue_q == 3'(RESCUE_STEPS - 1)) ? 3'h0 : rescue_q + 3'h1;
      end else begin
        rescue_q <= '0;
      end
    end
  end

  logic rescue_done;
  assign rescue_done = cs_rise && rescue_q == 3'(RESCUE_STEPS - 1)
                    && burst_q == RESCUE_LEN[rescue_q];

  // Transaction state machine
  always_ff @(posedge clock_i) begin
    if (!nrst_i || hw_reset || cs_n_s) begin
      state_q <= ST_IDLE;
      bits_q  <= '0;
      shift_q <= '0;
      cmd_q   <= '0;
    end else if (cs_fall) begin
      state_q <= xip_act_q ? ST_ADDR : ST_CMD;
      bits_q  <= '0;
      cmd_q   <= xip_act_q ? CMD_FAST_READ : 8'h00;
    end else if (sck_rise) begin
      bits_q <= bits_q + 6'h01;
      unique case (state_q)
        ST_CMD: begin
          cmd_q <= {cmd_q[6:0], pins_s[0]};
          if (bits_q == 6'(CMD_BITS - 1)) begin
            bits_q <= '0;
            if (!ready_q && {cmd_q[6:0], pins_s[0]} != CMD_READ_STATUS
                && {cmd_q[6:0], pins_s[0]} != CMD_READ_FLAG) begin
              state_q <= ST_IGNORE;
            end else begin
              unique case ({cmd_q[6:0], pins_s[0]})
                CMD_FAST_READ, CMD_DUAL_READ, CMD_QUAD_READ: state_q <= ST_ADDR;
                CMD_WRITE_VCFG:                              state_q <= ST_WCFG;
                CMD_READ_STATUS, CMD_READ_FLAG:              state_q <= ST_DATA;
                default:                                     state_q <= ST_IGNORE;
              endcase
            end
          end
        end
        ST_ADDR: begin
          unique case (proto_q)
            XMC_PROTO_QUAD: shift_q <= {shift_q[19:0], pins_s};
            XMC_PROTO_DUAL: shift_q <= {shift_q[21:0], pins_s[1:0]};
            default:        shift_q <= {shift_q[22:0], pins_s[0]};
          endcase
          if (bits_q == addr_cycles(proto_q) - 6'h01) begin
            bits_q  <= '0;
            state_q <= ST_DUMMY;
          end
        end
        ST_DUMMY:  state_q <= ST_DATA;
        ST_WCFG: begin
          shift_q <= {shift_q[22:0], pins_s[0]};
          if (bits_q == 6'h07) state_q <= ST_IGNORE;
        end
        default: ;
      endcase
    end
  end

  // Confirm bit capture and XIP state
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      xip_act_q  <= 1'b0;
      xip_next_q <= 1'b0;
      xip_pend_q <= 1'b0;
      vcfg_q     <= VCFG_RESET;
    end else if (hw_reset) begin
      xip_act_q  <= nv_xip(nvcfg_i);
      xip_next_q <= 1'b0;
      xip_pend_q <= 1'b0;
      vcfg_q     <= VCFG_RESET;
    end else if (!ready_q) begin
      xip_act_q <= nv_xip(nvcfg_i);
    end else begin
      if (!cs_n_s && sck_rise && state_q == ST_DUMMY) begin
        // Lines one to three are not looked at here
        if ((xip_act_q || !vcfg_q[VCFG_XIP_BIT] || basic_xip_i)
            && !pins_s[0]) begin
          xip_next_q <= 1'b1;
          xip_pend_q <= 1'b1;
        end else if (pins_s[0]) begin
          xip_next_q <= 1'b0;
          xip_pend_q <= 1'b1;
        end
      end
      if (!cs_n_s && sck_rise && state_q == ST_WCFG && bits_q == 6'h07) begin
        vcfg_q <= {shift_q[6:0], pins_s[0]};
      end
      if (rescue_done) begin
        xip_act_q  <= 1'b0;
        xip_pend_q <= 1'b0;
      end else if (cs_rise && xip_pend_q) begin
        xip_act_q  <= xip_next_q;
        xip_pend_q <= 1'b0;
        if (!xip_next_q) vcfg_q[VCFG_XIP_BIT] <= 1'b1;
      end
    end
  end

  // Status readback on line one
  always_ff @(posedge clock_i) begin
    if (!nrst_i || cs_n_s) begin
      out_byte_q         <= '0;
      out_cnt_q          <= '0;
      serial_line_o      <= '0;
      serial_line_oe_n_o <= 4'hF;
    end else if (state_q == ST_DATA && (cmd_q == CMD_READ_STATUS || cmd_q == CMD_READ_FLAG)) begin
      if (sck_fall) begin
        if (out_cnt_q == 3'h0) begin
          out_byte_q <= (cmd_q == CMD_READ_STATUS)
            ? 8'(op_busy_i || !ready_q) << STAT_WIP_BIT
            : 8'(!op_busy_i && ready_q) << FLAG_PEC_BIT;
          serial_line_o[1] <= (cmd_q == CMD_READ_STATUS) ? 1'b0 : (!op_busy_i && ready_q);
        end else begin
          serial_line_o[1] <= out_byte_q[3'd7 - out_cnt_q];
        end
        out_cnt_q             <= out_cnt_q + 3'h1;
        serial_line_oe_n_o[1] <= 1'b0;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      xip_active_o       <= 1'b0;
      xip_enabled_o      <= 1'b0;
      vcfg_o             <= VCFG_RESET;
      ready_o            <= 1'b0;
      hold_en_o          <= 1'b1;
      drive_default_o    <= 1'b1;
      reset_pin_active_o <= 1'b0;
      write_latch_o      <= 1'b0;
      lock_bits_o        <= 2'b00;
      cmd_valid_o        <= 1'b0;
      cmd_code_o         <= '0;
      addr_o             <= '0;
      proto_o            <= 2'(XMC_PROTO_EXT);
    end else begin
      xip_active_o       <= xip_act_q;
      xip_enabled_o      <= !vcfg_q[VCFG_XIP_BIT] || basic_xip_i;
      vcfg_o             <= vcfg_q;
      ready_o            <= ready_q;
      hold_en_o          <= !ready_q || nvcfg_i[4];
      drive_default_o    <= !ready_q || &nvcfg_i[8:5];
      reset_pin_active_o <= ready_q && reset_pin_en_i;
      write_latch_o      <= 1'b0;
      lock_bits_o        <= 2'b00;
      cmd_valid_o        <= ready_q && !cs_n_s && sck_rise && state_q == ST_DUMMY;
      // Held until the next read is sampled
      if (ready_q && !cs_n_s && sck_rise && state_q == ST_DUMMY) begin
        cmd_code_o <= cmd_q;
        addr_o     <= shift_q;
      end
      proto_o            <= 2'(proto_q);
    end
  end

endmodule // xmc_ctrl

// >>> common/xmc_pkg.sv
package xmc_pkg;

  // Clock and timing
  localparam int unsigned CLK_FREQ_MHZ       = 125;
  localparam int unsigned ACCESS_DELAY_US    = 300;
  localparam int unsigned ACCESS_DELAY_CYC   = ACCESS_DELAY_US * CLK_FREQ_MHZ;
  localparam int unsigned ERASE_REC_4K_NS    = 4_500_000;
  localparam int unsigned ERASE_REC_32K_NS   = 36_000_000;
  localparam int unsigned CLK_PERIOD_NS      = 8;
  localparam int unsigned ERASE_REC_4K_CYC   = ERASE_REC_4K_NS / CLK_PERIOD_NS;
  localparam int unsigned ERASE_REC_32K_CYC  = ERASE_REC_32K_NS / CLK_PERIOD_NS;
  localparam int unsigned DELAY_W            = 23;

  // Volatile and nonvolatile configuration fields
  localparam int unsigned VCFG_XIP_BIT       = 3;
  localparam int unsigned NVCFG_XIP_LSB      = 9;
  localparam int unsigned NVCFG_XIP_W        = 3;
  localparam logic [2:0]  NVCFG_XIP_OFF      = 3'h7;
  localparam int unsigned NVCFG_PROTO_LSB    = 2;
  localparam logic [7:0]  VCFG_RESET         = 8'hFB;

  // Protocol widths
  typedef enum logic [1:0] {
    XMC_PROTO_EXT,
    XMC_PROTO_DUAL,
    XMC_PROTO_QUAD
  } xmc_proto_type;

  // Command codes of the serial interface
  localparam logic [7:0] CMD_READ_STATUS     = 8'h05;
  localparam logic [7:0] CMD_READ_FLAG       = 8'h70;
  localparam logic [7:0] CMD_FAST_READ       = 8'h0B;
  localparam logic [7:0] CMD_DUAL_READ       = 8'hBB;
  localparam logic [7:0] CMD_QUAD_READ       = 8'hEB;
  localparam logic [7:0] CMD_WRITE_VCFG      = 8'h81;

  // Transaction shape
  localparam int unsigned ADDR_BITS          = 24;
  localparam int unsigned CMD_BITS           = 8;

  // Rescue burst lengths, in serial clock cycles
  localparam int unsigned RESCUE_STEPS       = 6;
  localparam logic [5:0]  RESCUE_LEN [RESCUE_STEPS] = '{6'd7, 6'd9, 6'd13, 6'd17, 6'd25, 6'd33};

  // Status and flag bit positions
  localparam int unsigned STAT_WIP_BIT       = 0;
  localparam int unsigned FLAG_PEC_BIT       = 7;

endpackage : xmc_pkg

// >>> rtl/xmc_sync.sv
module xmc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule // xmc_sync

// >>> verification/xmc_ctrl_assertions.sv
module xmc_ctrl_assertions
  import xmc_pkg::*;
(
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        nrst_i,
  // Pins and configuration
  input wire logic        chip_sel_n_i,
  input wire logic        reset_pin_n_i,
  input wire logic [15:0] nvcfg_i,
  input wire logic        basic_xip_i,
  // Design outputs
  input wire logic [3:0]  serial_line_oe_n_o,
  input wire logic        xip_active_o,
  input wire logic        xip_enabled_o,
  input wire logic [7:0]  vcfg_o,
  input wire logic        ready_o,
  input wire logic        hold_en_o,
  input wire logic        drive_default_o,
  input wire logic        reset_pin_active_o,
  input wire logic        write_latch_o,
  input wire logic [1:0]  lock_bits_o,
  input wire logic        cmd_valid_o,
  input wire logic [1:0]  proto_o
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);

  property p_init_refuse;
    !ready_o |-> !cmd_valid_o;
  endproperty
  a_init_refuse: assert property (p_init_refuse)
    else $error("read decoded before power-up completed");
  property p_init_pins;
    !ready_o |-> hold_en_o && drive_default_o && !reset_pin_active_o;
  endproperty
  a_init_pins: assert property (p_init_pins)
    else $error("pin functions wrong during access delay");
  property p_init_single;
    !ready_o |-> serial_line_oe_n_o[0] && serial_line_oe_n_o[3:2] == 2'b11;
  endproperty
  a_init_single: assert property (p_init_single)
    else $error("line other than line one driven before ready");
  property p_standby;
    ready_o |-> !write_latch_o && lock_bits_o == 2'b00;
  endproperty
  a_standby: assert property (p_standby)
    else $error("write latch or lock bits set after power-up");
  property p_exit_restore;
    $fell(xip_active_o) |-> ##[0:2] vcfg_o[VCFG_XIP_BIT];
  endproperty
  a_exit_restore: assert property (p_exit_restore)
    else $error("volatile XIP bit not restored on exit");
  property p_apply_deselect;
    $changed(xip_active_o) |-> chip_sel_n_i;
  endproperty
  a_apply_deselect: assert property (p_apply_deselect)
    else $error("XIP state changed inside a transaction");
  property p_enable_map;
    ($stable(vcfg_o) && $stable(basic_xip_i)) [*4]
      |-> xip_enabled_o == (!vcfg_o[VCFG_XIP_BIT] || basic_xip_i);
  endproperty
  a_enable_map: assert property (p_enable_map)
    else $error("XIP enable does not follow volatile bit");
  property p_no_reset;
    (ready_o && reset_pin_n_i) [*8] |=> ready_o;
  endproperty
  a_no_reset: assert property (p_no_reset)
    else $error("readiness lost without a reset");
  property p_proto;
    cmd_valid_o |-> proto_o == (nvcfg_i[3:2] == 2'b10 ? XMC_PROTO_DUAL :
      nvcfg_i[3:2] == 2'b01 ? XMC_PROTO_QUAD : XMC_PROTO_EXT);
  endproperty
  a_proto: assert property (p_proto)
    else $error("read width differs from configured protocol");
endmodule // xmc_ctrl_assertions

// >>> verification/xmc_host.sv
module xmc_host (
  // Frame alignment
  input  wire logic       clock_i,
  // Serial pins
  input  wire logic [3:0] serial_line_i,
  output logic            chip_sel_n_o,
  output logic            serial_clk_o,
  output logic      [3:0] serial_line_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Serial clock stands low outside frames
  initial begin
    chip_sel_n_o = 1'b1;
    serial_clk_o = 1'b0;
    serial_line_o = 4'hA;
  end

  task automatic sel();
    @(posedge clock_i);
    #1 chip_sel_n_o = 1'b0;
  endtask

  // Reply taken late in the high phase, well after the device's relaunch
  task automatic pulse(output logic r);
    #40 serial_clk_o = 1'b1;
    #32 r = serial_line_i[1];
    #8 serial_clk_o = 1'b0;
  endtask

  task automatic sh8(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      serial_line_o[0] = d[i];
      pulse(r[i]);
    end
  endtask

  task automatic sh24(input logic [23:0] a);
    logic r;
    for (int i = 23; i >= 0; i--) begin
      serial_line_o[0] = a[i];
      pulse(r);
    end
  endtask

  // Upper lines carry the opposite value so a wrong pick shows
  task automatic dummy(input logic c);
    logic r;
    serial_line_o = {{3{~c}}, c};
    pulse(r);
  endtask

  // Released lines flip so a stale value is never read as valid
  task automatic desel();
    #40 chip_sel_n_o = 1'b1;
    serial_line_o = ~serial_line_o;
    #200;
  endtask

  task automatic burst(input logic [5:0] n);
    logic r;
    sel();
    serial_line_o = 4'hF;
    repeat (n) pulse(r);
    desel();
  endtask
endmodule // xmc_host

// >>> verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import xmc_pkg::*;

  // Short access delay keeps the run brief
  localparam int unsigned ACC = 1500;

  logic        clock_i;
  logic        nrst_i = 1'b0;
  logic        reset_pin_n_i = 1'b1;
  logic        basic_xip_i = 1'b0;
  logic        reset_pin_en_i = 1'b1;
  logic        op_busy_i = 1'b0;
  logic [15:0] nvcfg_i = 16'hFFFF;
  wire logic   chip_sel_n_i;
  wire logic   serial_clk_i;
  wire logic [3:0] host_line;
  wire logic [3:0] line_w;
  logic [3:0]  serial_line_o;
  logic [3:0]  serial_line_oe_n_o;
  logic        xip_active_o;
  logic        xip_enabled_o;
  logic [7:0]  vcfg_o;
  logic        ready_o;
  logic        hold_en_o;
  logic        drive_default_o;
  logic        reset_pin_active_o;
  logic        write_latch_o;
  logic [1:0]  lock_bits_o;
  logic        cmd_valid_o;
  logic [7:0]  cmd_code_o;
  logic [23:0] addr_o;
  logic [1:0]  proto_o;
  logic [7:0]  rx;
  int          errors = 0;
  int          checked = 0;
  int          cyc = 0;
  int          vcnt = 0;
  int          t0;
  int          v0;

  assign line_w = (serial_line_oe_n_o & host_line) | (~serial_line_oe_n_o & serial_line_o);

  xmc_ctrl #(.ACCESS_CYC(ACC), .REC4_CYC(60), .REC32_CYC(70)) u_dut (
    .clock_i, .nrst_i, .chip_sel_n_i, .serial_clk_i, .serial_line_i(line_w),
    .reset_pin_n_i, .serial_line_o, .serial_line_oe_n_o, .nvcfg_i, .basic_xip_i,
    .reset_pin_en_i, .erase_recovery_i(2'b00), .op_busy_i, .xip_active_o,
    .xip_enabled_o, .vcfg_o, .ready_o, .hold_en_o, .drive_default_o,
    .reset_pin_active_o, .write_latch_o, .lock_bits_o, .cmd_valid_o, .cmd_code_o,
    .addr_o, .proto_o);

  xmc_host u_host (.clock_i, .serial_line_i(line_w), .chip_sel_n_o(chip_sel_n_i),
    .serial_clk_o(serial_clk_i), .serial_line_o(host_line));

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cyc++;
    if (cmd_valid_o === 1'b1) vcnt++;
    if (cyc == 20000) begin
      errors++;
      $display("[ERR] %0t run did not finish", $time);
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t check %0d got %h expected %h", $time, checked, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic do_reset(input logic [15:0] nv);
    nrst_i = 1'b0;
    nvcfg_i = nv;
    tick(2);
    chk(vcfg_o, VCFG_RESET);
    chk(serial_line_oe_n_o, 4'hF);
    chk({ready_o, xip_active_o, cmd_valid_o}, 3'b000);
    nrst_i = 1'b1;
    t0 = cyc;
  endtask

  task automatic wait_ready();
    while (ready_o !== 1'b1 && cyc - t0 < ACC + 100) tick(1);
    chk(ready_o, 1'b1);
  endtask

  task automatic fread(input logic xip, input logic [23:0] a, input logic c);
    logic [7:0] r;
    u_host.sel();
    if (!xip) u_host.sh8(CMD_FAST_READ, r);
    u_host.sh24(a);
    u_host.dummy(c);
    u_host.desel();
    tick(1);
  endtask

  task automatic reg8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    u_host.sel();
    u_host.sh8(c, r);
    u_host.sh8(d, rx);
    u_host.desel();
    tick(1);
  endtask

  initial begin
    do_reset(16'hFFFF);
    v0 = vcnt;
    fread(1'b0, 24'h12_3456, 1'b0);
    chk(vcnt - v0, 0);
    chk(xip_active_o, 1'b0);
    reg8(CMD_READ_FLAG, 8'h00);
    chk(rx[FLAG_PEC_BIT], 1'b0);
    reg8(CMD_READ_STATUS, 8'h00);
    chk(rx[STAT_WIP_BIT], 1'b1);
    wait_ready();
    chk(cyc - t0 >= ACC, 1'b1);
    chk({write_latch_o, lock_bits_o, reset_pin_active_o}, 4'h1);
    for (int b = 0; b < 2; b++) begin
      op_busy_i = b[0];
      reg8(CMD_READ_FLAG, 8'h00);
      chk(rx[FLAG_PEC_BIT], !b[0]);
    end
    op_busy_i = 1'b0;
    reg8(CMD_WRITE_VCFG, 8'hF3);
    chk({vcfg_o, xip_enabled_o, xip_active_o}, {8'hF3, 2'b10});
    v0 = vcnt;
    fread(1'b0, 24'hA5_5A3C, 1'b0);
    chk({vcnt - v0, addr_o, cmd_code_o}, {32'd1, 24'hA5_5A3C, CMD_FAST_READ});
    chk(xip_active_o, 1'b1);
    for (int i = 0; i < 2; i++) begin
      fread(1'b1, 24'h00_0FF0 + 24'(i), i[0]);
      chk(vcnt - v0, 2 + i);
      chk(addr_o, 24'h00_0FF0 + 24'(i));
      chk(xip_active_o, !i[0]);
    end
    chk(vcfg_o, VCFG_RESET);
    basic_xip_i = 1'b1;
    fread(1'b0, 24'h00_1234, 1'b0);
    chk({xip_active_o, vcfg_o, vcnt - v0}, {1'b1, VCFG_RESET, 32'd4});
    op_busy_i = 1'b1;
    for (int k = 0; k < RESCUE_STEPS; k++) u_host.burst(RESCUE_LEN[k]);
    tick(1);
    chk({xip_active_o, ready_o}, 2'b01);
    reg8(8'hA1, 8'h00);
    reg8(8'hA2, 8'h00);
    chk({xip_active_o, ready_o}, 2'b01);
    reg8(CMD_READ_FLAG, 8'h00);
    chk(rx[FLAG_PEC_BIT], 1'b0);
    op_busy_i = 1'b0;
    fread(1'b0, 24'h00_2468, 1'b0);
    chk(xip_active_o, 1'b1);
    reset_pin_n_i = 1'b0;
    tick(6);
    reset_pin_n_i = 1'b1;
    tick(8);
    chk(xip_active_o, 1'b0);
    basic_xip_i = 1'b0;
    do_reset(16'hF1FF);
    wait_ready();
    v0 = vcnt;
    fread(1'b1, 24'h45_6789, 1'b0);
    chk({vcnt - v0, addr_o, xip_active_o}, {32'd1, 24'h45_6789, 1'b1});
    end_of_test();
  end
endmodule // testbench

bind xmc_ctrl xmc_ctrl_assertions u_chk (
  .clock_i, .nrst_i, .chip_sel_n_i, .reset_pin_n_i, .nvcfg_i, .basic_xip_i,
  .serial_line_oe_n_o, .xip_active_o, .xip_enabled_o, .vcfg_o, .ready_o, .hold_en_o,
  .drive_default_o, .reset_pin_active_o, .write_latch_o, .lock_bits_o, .cmd_valid_o,
  .proto_o);
